// ---- logic/sbc_pkg.sv ----
// Shared constants and types for the serial BCD clock/calendar and its bus master
package sbc_pkg;
  // Bus addressing
  localparam logic [6:0] SBC_SLAVE_ADDR = 7'h68;
  localparam logic [5:0] ADR_SEC       = 6'h00;
  localparam logic [5:0] ADR_CTRL      = 6'h07;
  localparam logic [5:0] ADR_RAM_FIRST = 6'h08;
  localparam int         SBC_RAM_LAST  = 63;

  // Field positions
  localparam int HALT_BIT     = 7;
  localparam int CEN_EN_BIT   = 7;
  localparam int CEN_FLAG_BIT = 6;
  localparam int OUT_BIT      = 7;
  localparam int TEST_BIT     = 6;
  localparam int SIGN_BIT     = 5;

  // Reset values
  localparam logic [7:0]      SBC_CTRL_RESET = 8'h80;
  localparam logic [6:0][7:0] SBC_CAL_RESET  = 56'h00_01_01_01_00_00_00;

  // Timing
  localparam int SBC_OSC_HZ    = 32768;
  localparam int SBC_TEST_HZ   = 512;
  localparam int SBC_DEFER_MS  = 250;
  localparam int SBC_CLK_NS    = 50;
  localparam int SBC_SCL_NS    = 10000;
  localparam int SBC_SCL_QTR   = SBC_SCL_NS / (4 * SBC_CLK_NS);

  // Host register map (byte addresses) and fields
  localparam logic [3:0] AV_CMD      = 4'h0;
  localparam logic [3:0] AV_RX       = 4'h4;
  localparam int         CMD_ACK_BIT = 2;
  localparam int         CMD_TX_LSB  = 8;
  localparam int         STS_BUSY    = 0;
  localparam int         STS_NACK    = 1;

  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_WRITE = 2'b01,
    OP_READ  = 2'b10,
    OP_STOP  = 2'b11
  } sbc_op_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_WADR = 3'b010,
    S_WDAT = 3'b011,
    S_RDAT = 3'b100
  } sbc_slv_t;
endpackage

// ---- logic/sbc_i2c_if.sv ----
// Two-wire bus between the clock device and its bus master
`timescale 1ns/1ps
interface sbc_i2c_if;
  logic scl_o;
  logic scl_oe;
  logic hsda_o;
  logic hsda_oe;
  logic dsda_o;
  logic dsda_oe;
  wire  scl;
  wire  sda;

  // Open-drain wired-AND with pull-up
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (hsda_oe ? hsda_o : 1'b1) & (dsda_oe ? dsda_o : 1'b1);

  modport dev  (input scl, input sda, output dsda_o, output dsda_oe);
  modport host (input sda, output scl_o, output scl_oe, output hsda_o, output hsda_oe);
endinterface

// ---- logic/sbc_calendar.sv ----
// BCD time and date counters with month length and leap year handling
`timescale 1ns/1ps
module sbc_calendar
  import sbc_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            nrst,
  input  wire logic            tick,
  input  wire logic            wr_en,
  input  wire logic [2:0]      wr_addr,
  input  wire logic [7:0]      wr_data,
  output logic      [6:0][7:0] cal
);
  // Returns {carry, next}; wraps to low at lim
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] lim,
                                          input logic [7:0] low);
    if (v >= lim) begin
      return {1'b1, low};
    end
    if (v[3:0] >= 4'h9) begin
      return {1'b0, v[7:4] + 4'h1, 4'h0};
    end
    return {1'b0, v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    unique case (mon)
      8'h02:                      return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default:                    return 8'h31;
    endcase
  endfunction

  wire [7:0] dim = month_len({3'h0, cal[5][4:0]}, cal[6]);
  wire [8:0] s   = bcd_step({1'b0, cal[0][6:0]}, 8'h59, 8'h00);
  wire [8:0] m   = bcd_step({1'b0, cal[1][6:0]}, 8'h59, 8'h00);
  wire [8:0] h   = bcd_step({2'h0, cal[2][5:0]}, 8'h23, 8'h00);
  wire [8:0] dw  = bcd_step({5'h00, cal[3][2:0]}, 8'h07, 8'h01);
  wire [8:0] dt  = bcd_step({2'h0, cal[4][5:0]}, dim, 8'h01);
  wire [8:0] mo  = bcd_step({3'h0, cal[5][4:0]}, 8'h12, 8'h01);
  wire [8:0] y   = bcd_step(cal[6], 8'h99, 8'h00);

  wire c_s  = s[8];
  wire c_m  = c_s & m[8];
  wire c_h  = c_m & h[8];
  wire c_d  = c_h & dt[8];
  wire c_mo = c_d & mo[8];
  wire c_y  = c_mo & y[8];
  wire cen  = cal[2][CEN_FLAG_BIT] ^ (c_y & cal[2][CEN_EN_BIT]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cal <= SBC_CAL_RESET;
    end else if (wr_en) begin
      cal[wr_addr] <= wr_data;
    end else if (tick) begin
      cal[0][6:0] <= s[6:0];
      if (c_s) begin
        cal[1][6:0] <= m[6:0];
      end
      if (c_m) begin
        cal[2][6:0] <= {cen, h[5:0]};
      end
      if (c_h) begin
        cal[3][2:0] <= dw[2:0];
        cal[4][5:0] <= dt[5:0];
      end
      if (c_d) begin
        cal[5][4:0] <= mo[4:0];
      end
      if (c_mo) begin
        cal[6] <= y[7:0];
      end
    end
  end
endmodule

// ---- logic/sbc_rtc_dev.sv ----
// Clock/calendar device end: bus slave, pointer, RAM, timekeeping and test output
// Function
// - Random read: pointer write, repeated START, read
// - Pointer advances only on received acknowledge
// - Stream consecutive bytes while master acknowledges
// - Plain read starts at current pointer
// - Direction 0 makes next byte the pointer
// - Data byte stored, pointer advances on acknowledge
// - Acknowledge address, pointer and every data byte
// - Power fail deselects and blocks writes
// - Time and date kept as BCD fields
// - Century flag toggles at rollover when enabled
// - Day of week in bits two to zero
// - Halt bit stops oscillator, clear restarts it
// - Clock reads defer register update up to 250ms
// - Control register holds output, test, calibration
// - Host sets then clears halt after power-up
// - Respond only to fixed slave address
// - Sixty-four locations: clock, control, then RAM
// - Test bit gives 512Hz, else level bit
// - Power-on: test bit 0, level bit 1
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
module sbc_rtc_dev
  import sbc_pkg::*;
#(
  parameter int OSC_HZ = SBC_OSC_HZ
) (
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  sbc_i2c_if.dev      bus,
  input  wire logic   osc_in,
  input  wire logic   pwr_fail,
  output logic        pin_o,
  output logic        pin_oe
);
  localparam int TEST_HALF   = OSC_HZ / (2 * SBC_TEST_HZ);
  localparam int DEFER_TICKS = OSC_HZ * SBC_DEFER_MS / 1000;

  logic [3:0]      sy1;
  logic [3:0]      sy2;
  logic [3:0]      sy3;
  sbc_slv_t        slv_state;
  logic [3:0]      cnt;
  logic [7:0]      sh;
  logic [7:0]      tx;
  logic [5:0]      ptr;
  logic [7:0]      ctrl;
  logic [7:0]      ram [ADR_RAM_FIRST:SBC_RAM_LAST];
  logic [6:0][7:0] cal;
  logic [15:0]     pres;
  logic [15:0]     dcnt;
  logic [15:0]     fcnt;
  logic            pend;
  logic            sq;

  // Pin synchronisers: scl, sda, oscillator, power fail
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sy1 <= 4'hf;
      sy2 <= 4'hf;
      sy3 <= 4'hf;
    end else begin
      sy1 <= {pwr_fail, osc_in, bus.sda, bus.scl};
      sy2 <= sy1;
      sy3 <= sy2;
    end
  end

  wire scl       = sy2[0];
  wire sda       = sy2[1];
  wire pf        = sy2[3];
  wire scl_rise  = scl & ~sy3[0];
  wire scl_fall  = ~scl & sy3[0];
  wire start_c   = scl & sy3[0] & sy3[1] & ~sda;
  wire stop_c    = scl & sy3[0] & ~sy3[1] & sda;
  wire osc_tick  = sy2[2] & ~sy3[2];
  wire halted    = cal[0][HALT_BIT];
  wire match     = sh[7:1] == SBC_SLAVE_ADDR;
  wire ack_rise  = scl_rise & (cnt == 4'd8) & (slv_state != S_IDLE);
  wire wr_now    = ack_rise & (slv_state == S_WDAT) & ~pf;
  wire [5:0] ptr_inc = ptr + 6'h01;
  wire [5:0] rd_sel  = (slv_state == S_ADDR) ? ptr : ptr_inc;
  wire [7:0] rd_byte = (rd_sel < ADR_CTRL) ? cal[rd_sel[2:0]] :
                       (rd_sel == ADR_CTRL) ? ctrl : ram[rd_sel];
  wire [2:0] bit_ix  = 3'(4'd7 - cnt);
  wire       rd_clk  = (slv_state == S_RDAT) & (ptr < ADR_CTRL);
  wire       apply   = pend & (~rd_clk | (dcnt == 16'(DEFER_TICKS - 1)));
  wire       cal_we  = wr_now & (ptr < ADR_CTRL);
  wire       level   = ctrl[TEST_BIT] ? sq : ctrl[OUT_BIT];

  // Slave byte engine
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      slv_state   <= S_IDLE;
      cnt         <= 4'd0;
      sh          <= 8'h00;
      tx          <= 8'hff;
      ptr         <= 6'h00;
      bus.dsda_oe <= 1'b0;
    end else if (pf) begin
      slv_state   <= S_IDLE;
      cnt         <= 4'd0;
      ptr         <= 6'h00;
      bus.dsda_oe <= 1'b0;
    end else if (start_c) begin
      slv_state   <= S_ADDR;
      cnt         <= 4'd0;
      bus.dsda_oe <= 1'b0;
    end else if (stop_c) begin
      slv_state   <= S_IDLE;
      bus.dsda_oe <= 1'b0;
    end else if (scl_rise && slv_state != S_IDLE) begin
      if (cnt < 4'd8) begin
        sh  <= {sh[6:0], sda};
        cnt <= cnt + 4'd1;
      end else begin
        cnt <= 4'd9;
        unique case (slv_state)
          S_ADDR: begin
            if (sh[0]) begin
              slv_state <= S_RDAT;
              tx        <= rd_byte;
            end else begin
              slv_state <= S_WADR;
            end
          end
          S_WADR: begin
            ptr       <= sh[5:0];
            slv_state <= S_WDAT;
          end
          S_WDAT: begin
            ptr <= ptr_inc;
          end
          S_RDAT: begin
            if (!sda) begin
              ptr <= ptr_inc;
              tx  <= rd_byte;
            end else begin
              slv_state <= S_IDLE;
            end
          end
          S_IDLE: begin
            slv_state <= S_IDLE;
          end
        endcase
      end
    end else if (scl_fall && slv_state != S_IDLE) begin
      if (cnt == 4'd8) begin
        bus.dsda_oe <= (slv_state != S_RDAT) & ((slv_state != S_ADDR) | match);
        if (slv_state == S_ADDR && !match) begin
          slv_state <= S_IDLE;
        end
      end else if (cnt == 4'd9) begin
        cnt         <= 4'd0;
        bus.dsda_oe <= (slv_state == S_RDAT) & ~tx[7];
      end else if (slv_state == S_RDAT && cnt != 4'd0) begin
        bus.dsda_oe <= ~tx[bit_ix];
      end
    end
  end

  // Open-drain drivers only ever pull low
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus.dsda_o <= 1'b0;
      pin_o      <= 1'b0;
      pin_oe     <= 1'b0;
    end else begin
      bus.dsda_o <= 1'b0;
      pin_o      <= 1'b0;
      pin_oe     <= ~level;
    end
  end

  // Control register and RAM
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ctrl <= SBC_CTRL_RESET;
    end else if (wr_now && ptr == ADR_CTRL) begin
      ctrl <= sh;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (wr_now && ptr >= ADR_RAM_FIRST) begin
      ram[ptr] <= sh;
    end
  end

  // Second prescaler, halted with its count cleared
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pres <= 16'h0000;
    end else if (halted) begin
      pres <= 16'h0000;
    end else if (osc_tick) begin
      pres <= (pres == 16'(OSC_HZ - 1)) ? 16'h0000 : pres + 16'h0001;
    end
  end

  wire sec_tick = osc_tick & ~halted & (pres == 16'(OSC_HZ - 1));

  // Deferred register update while a clock location is read
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pend <= 1'b0;
      dcnt <= 16'h0000;
    end else begin
      pend <= sec_tick | (pend & ~apply);
      if (!pend || apply) begin
        dcnt <= 16'h0000;
      end else if (osc_tick) begin
        dcnt <= dcnt + 16'h0001;
      end
    end
  end

  // 512Hz test square from the oscillator
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fcnt <= 16'h0000;
      sq   <= 1'b0;
    end else if (osc_tick && !halted) begin
      if (fcnt == 16'(TEST_HALF - 1)) begin
        fcnt <= 16'h0000;
        sq   <= ~sq;
      end else begin
        fcnt <= fcnt + 16'h0001;
      end
    end
  end

  sbc_calendar sbc_calendar_inst (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .tick    (apply),
    .wr_en   (cal_we),
    .wr_addr (ptr[2:0]),
    .wr_data (sh),
    .cal     (cal)
  );
endmodule

// ---- logic/sbc_i2c_host.sv ----
// Bus master end: Avalon-MM command registers driving START, byte, STOP sequences
`timescale 1ns/1ps
module sbc_i2c_host
  import sbc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [3:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [31:0] av_writedata,
  output logic      [31:0] av_readdata,
  output logic             av_waitrequest,
  sbc_i2c_if.host          bus
);
  logic    [1:0] hs;
  logic          busy;
  logic          nack;
  logic          ackb;
  sbc_op_t       op;
  logic    [7:0] sh;
  logic    [7:0] rx;
  logic    [1:0] q;
  logic    [7:0] qcnt;
  logic    [3:0] bitn;

  wire       acc     = (av_read | av_write) & av_waitrequest;
  wire       cmd_hit = av_write & (av_address == AV_CMD);
  wire       ok      = ~(cmd_hit & busy);
  wire       go      = acc & ok & cmd_hit;
  wire       qt      = busy & (qcnt == 8'(SBC_SCL_QTR - 1));
  wire       sda_in  = hs[1];
  wire       last    = bitn[3];
  wire [31:0] rd_mux = (av_address == AV_CMD) ? {30'h0, nack, busy} :
                       (av_address == AV_RX) ? {24'h0, rx} : 32'h0;
  wire       bit_lvl = (op == OP_WRITE) ? (last | sh[7]) : (last ? ~ackb : 1'b1);

  // Avalon slave: one wait cycle, writes to a busy command register stall
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      av_waitrequest <= 1'b1;
      av_readdata    <= 32'h0;
    end else begin
      av_waitrequest <= ~(acc & ok);
      if (acc && ok && av_read) begin
        av_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      hs <= 2'b11;
    end else begin
      hs <= {hs[0], bus.sda};
    end
  end

  // Bit sequencer, four quarter phases per bit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      busy        <= 1'b0;
      nack        <= 1'b0;
      ackb        <= 1'b0;
      op          <= OP_STOP;
      sh          <= 8'h00;
      rx          <= 8'h00;
      q           <= 2'd0;
      qcnt        <= 8'h00;
      bitn        <= 4'd0;
      bus.scl_oe  <= 1'b0;
      bus.hsda_oe <= 1'b0;
    end else if (go) begin
      busy <= 1'b1;
      op   <= sbc_op_t'(av_writedata[1:0]);
      ackb <= av_writedata[CMD_ACK_BIT];
      sh   <= av_writedata[CMD_TX_LSB +: 8];
      q    <= 2'd0;
      qcnt <= 8'h00;
      bitn <= 4'd0;
    end else if (busy) begin
      qcnt <= qt ? 8'h00 : qcnt + 8'h01;
      if (qt) begin
        q <= q + 2'd1;
        unique case (op)
          OP_START: begin
            unique case (q)
              2'd0: bus.hsda_oe <= 1'b0;
              2'd1: bus.scl_oe  <= 1'b0;
              2'd2: bus.hsda_oe <= 1'b1;
              2'd3: begin
                bus.scl_oe <= 1'b1;
                op         <= OP_WRITE;
              end
            endcase
          end
          OP_WRITE, OP_READ: begin
            unique case (q)
              2'd0: bus.hsda_oe <= ~bit_lvl;
              2'd1: bus.scl_oe  <= 1'b0;
              2'd2: begin
                if (last) begin
                  nack <= sda_in;
                end else if (op == OP_READ) begin
                  rx <= {rx[6:0], sda_in};
                end
              end
              2'd3: begin
                bus.scl_oe <= 1'b1;
                sh         <= {sh[6:0], 1'b0};
                bitn       <= bitn + 4'd1;
                busy       <= ~last;
              end
            endcase
          end
          OP_STOP: begin
            unique case (q)
              2'd0: bus.hsda_oe <= 1'b1;
              2'd1: bus.scl_oe  <= 1'b0;
              2'd2: bus.hsda_oe <= 1'b0;
              2'd3: busy        <= 1'b0;
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      bus.scl_o  <= 1'b0;
      bus.hsda_o <= 1'b0;
    end else begin
      bus.scl_o  <= 1'b0;
      bus.hsda_o <= 1'b0;
    end
  end
endmodule

// ---- verification/sbc_rtc_monitor.sv ----
// Wire-level checker for the two-wire bus between the host and the clock device
`timescale 1ns/1ps
module sbc_rtc_monitor
  import sbc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic pwr_fail,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic hsda_oe,
  input  wire logic dsda_oe
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic       first;
  logic       rd;
  logic       acked;
  wire        start    = scl && scl_q && sda_q && !sda;
  wire        stop     = scl && scl_q && !sda_q && sda;
  wire        rise     = scl && !scl_q;
  wire        ack_rise = rise && (cnt == 4'h8);
  wire        hit      = (sh[7:1] == SBC_SLAVE_ADDR) && !pwr_fail;

  // Bit position within the byte, 9 marks the acknowledge slot
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      cnt   <= 4'h0;
      sh    <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) begin
        cnt <= 4'h0;
      end else if (rise) begin
        cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      end
      if (rise && cnt != 4'h8) begin
        sh <= {sh[6:0], sda};
      end
    end
  end

  // Transfer state: first byte pending, direction, addressed
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      first <= 1'b0;
      rd    <= 1'b0;
      acked <= 1'b0;
    end else if (start) begin
      first <= 1'b1;
      rd    <= 1'b0;
      acked <= 1'b0;
    end else if (stop) begin
      rd    <= 1'b0;
      acked <= 1'b0;
    end else if (ack_rise && first) begin
      first <= 1'b0;
      rd    <= sh[0] && !sda;
      acked <= !sda;
    end
  end

  default clocking mon_clk @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_ack_match;
    ack_rise && first && hit |-> !sda;
  endproperty
  a_ack_match: assert property (p_ack_match) else $error("address not acknowledged");

  property p_ack_other;
    ack_rise && first && !hit |-> !dsda_oe;
  endproperty
  a_ack_other: assert property (p_ack_other) else $error("foreign address answered");

  property p_wr_ack;
    ack_rise && !first && acked && !rd |-> !sda;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("written byte not acknowledged");

  property p_wr_window;
    dsda_oe && !rd |-> cnt >= 4'h8;
  endproperty
  a_wr_window: assert property (p_wr_window) else $error("device drove outside ack");

  property p_rd_release;
    ack_rise && !first && rd |-> !dsda_oe;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("device held ack slot");

  property p_rd_stable;
    rd && scl && scl_q |-> $stable(dsda_oe);
  endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("data changed, clock high");

  property p_nack_quiet;
    ack_rise && !first && rd && sda |-> ##1 (!dsda_oe) [*8];
  endproperty
  a_nack_quiet: assert property (p_nack_quiet) else $error("device drove after nack");

  property p_start_host;
    start |-> hsda_oe;
  endproperty
  a_start_host: assert property (p_start_host) else $error("start not made by host");
endmodule

// ---- verification/serial_bcd_clock_calendar_tb.sv ----
// Testbench: host and clock device joined on one two-wire bus
`timescale 1ns/1ps
module serial_bcd_clock_calendar_tb;
  import sbc_pkg::*;
  logic              clk_sys      = 1'b0;
  logic              nrst         = 1'b0;
  logic              pwr_fail     = 1'b0;
  logic [3:0]        av_address   = 4'h0;
  logic              av_read      = 1'b0;
  logic              av_write     = 1'b0;
  logic [31:0]       av_writedata = 32'h0;
  logic [2:0]        osc_cnt      = 3'h0;
  logic [31:0]       av_readdata;
  logic              av_waitrequest;
  logic              pin_o;
  logic              pin_oe;
  wire               osc_in;
  logic [0:15][7:0]  rb;
  int                err_total    = 0;
  int                n_checks     = 0;

  sbc_i2c_if bus ();
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) osc_cnt <= osc_cnt + 3'h1;
  assign osc_in = osc_cnt[2];

  sbc_rtc_dev #(.OSC_HZ(1024)) sbc_rtc_dev_inst (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .bus     (bus),
    .osc_in  (osc_in),
    .pwr_fail(pwr_fail),
    .pin_o   (pin_o),
    .pin_oe  (pin_oe)
  );
  sbc_i2c_host sbc_i2c_host_inst (
    .clk_sys       (clk_sys),
    .nrst          (nrst),
    .av_address    (av_address),
    .av_read       (av_read),
    .av_write      (av_write),
    .av_writedata  (av_writedata),
    .av_readdata   (av_readdata),
    .av_waitrequest(av_waitrequest),
    .bus           (bus)
  );
  sbc_rtc_monitor sbc_rtc_monitor_inst (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .pwr_fail(pwr_fail),
    .scl     (bus.scl),
    .sda     (bus.sda),
    .hsda_oe (bus.hsda_oe),
    .dsda_oe (bus.dsda_oe)
  );

  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic timeout();
    err_total++;
    $display("ERROR %0t: wait bound exceeded", $time);
    end_sim();
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int i;
    av_address   <= a;
    av_writedata <= d;
    av_write     <= wr;
    av_read      <= ~wr;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (av_waitrequest !== 1'b0 && i < 5000);
    q = av_readdata;
    av_write <= 1'b0;
    av_read  <= 1'b0;
    @(posedge clk_sys);
    if (i >= 5000) timeout();
  endtask

  // One bus command, then poll until idle; returns the nack flag
  task automatic op(input sbc_op_t c, input logic [7:0] b, input logic ak,
                    output logic nk);
    logic [31:0] q;
    int          i;
    av(1'b1, AV_CMD, {16'h0, b, 5'h0, ak, c}, q);
    i = 0;
    do begin
      av(1'b0, AV_CMD, 32'h0, q);
      i++;
    end while (q[STS_BUSY] !== 1'b0 && i < 3000);
    nk = q[STS_NACK];
    if (i >= 3000) timeout();
  endtask

  task automatic put(input logic [5:0] a, input int n);
    logic nk;
    op(OP_START, 8'hd0, 1'b0, nk);
    chk({7'h0, nk}, 8'h00);
    op(OP_WRITE, {2'b00, a}, 1'b0, nk);
    chk({7'h0, nk}, 8'h00);
    for (int k = 0; k < n; k++) begin
      op(OP_WRITE, rb[k], 1'b0, nk);
      chk({7'h0, nk}, 8'h00);
    end
    op(OP_STOP, 8'h00, 1'b0, nk);
  endtask

  // Read n bytes, acknowledging all but the last; optional pointer load first
  task automatic get(input logic ptr, input logic [5:0] a, input int n);
    logic        nk;
    logic [31:0] q;
    if (ptr) begin
      op(OP_START, 8'hd0, 1'b0, nk);
      op(OP_WRITE, {2'b00, a}, 1'b0, nk);
    end
    op(OP_START, 8'hd1, 1'b0, nk);
    chk({7'h0, nk}, 8'h00);
    for (int k = 0; k < n; k++) begin
      op(OP_READ, 8'h00, k < n - 1, nk);
      av(1'b0, AV_RX, 32'h0, q);
      chk(q[7:0], rb[k]);
    end
    op(OP_STOP, 8'h00, 1'b0, nk);
  endtask

  initial begin
    logic        nk;
    logic [31:0] q;
    logic        po;
    int          tg;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({7'h0, pin_oe}, 8'h00);
    chk({7'h0, pin_o}, 8'h00);
    av(1'b0, 4'hc, 32'h0, q);
    chk(q[7:0], 8'h00);
    for (int k = 0; k < 4; k++) rb[k] = SBC_CAL_RESET[k];
    get(1'b0, 6'h00, 4);
    // Wrap from the top of RAM into the halted clock registers
    rb[0:8] = {8'ha5, 8'h5a, 8'h80, 8'h59, 8'he3, 8'h07, 8'h31, 8'h12, 8'h99};
    put(6'h3e, 9);
    get(1'b1, 6'h3e, 3);
    rb[0] = 8'h80;
    get(1'b0, 6'h00, 1);
    op(OP_START, 8'ha0, 1'b0, nk);
    chk({7'h0, nk}, 8'h01);
    op(OP_STOP, 8'h00, 1'b0, nk);
    pwr_fail <= 1'b1;
    repeat (8) @(posedge clk_sys);
    op(OP_START, 8'hd0, 1'b0, nk);
    chk({7'h0, nk}, 8'h01);
    op(OP_STOP, 8'h00, 1'b0, nk);
    pwr_fail <= 1'b0;
    repeat (8) @(posedge clk_sys);
    // Release the halt at 59 s and let one second pass
    rb[0] = 8'h59;
    put(6'h00, 1);
    repeat (9000) @(posedge clk_sys);
    rb[0:5] = {8'h00, 8'h80, 8'h01, 8'h01, 8'h01, 8'h00};
    get(1'b1, 6'h01, 6);
    rb[0] = 8'hc0;
    put(6'h07, 1);
    po = pin_oe;
    tg = 0;
    for (int k = 0; k < 160; k++) begin
      @(posedge clk_sys);
      if (pin_oe !== po) tg++;
      po = pin_oe;
    end
    chk({7'h0, (tg >= 19 && tg <= 21)}, 8'h01);
    rb[0] = 8'h00;
    put(6'h07, 1);
    chk({7'h0, pin_oe}, 8'h01);
    end_sim();
  end
endmodule
